// ---- memory_space_address_decoder_tb.sv ----
/*
 testbench for the address decoder: counter, table, data paths.
 assumes the ram model below; inputs change on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module memory_space_address_decoder_tb;
  import msad_pkg::*;
  logic clock = 0, rst = 1, pc_advance = 0, pc_reverse = 0, pc_load = 0;
  logic [22:0] pc_load_value = 23'h0;
  logic table_read_op = 0, table_upper = 0, psv_enable = 0, rd_valid = 0, rd_byte = 0;
  logic wr_valid = 0, wr_byte = 0, prog_upper_word, prog_access_ok, in_primary_vectors;
  logic [7:0] table_page_register = 8'h00, psv_page = 8'h00;
  logic [15:0] prog_rdata = 16'h0000;
  logic [15:0] table_offset = 16'h0, rd_ea = 16'h0, wr_ea = 16'h0, wr_data = 16'h0;
  logic [15:0] dram_rdata, dram_wdata, rd_data;
  logic [22:0] pc;
  logic [23:0] prog_addr;
  logic [5:0] region_sel;
  logic [14:0] dram_raddr, dram_waddr;
  logic [1:0] dram_wlane;
  logic in_alt_vectors, rd_data_valid, addr_error_trap;
  int error_cnt = 0, n_compared = 0;
  always #20 clock = ~clock;
  msad_decoder dut (.clock(clock), .rst(rst), .pc_advance(pc_advance), .pc_reverse(pc_reverse),
    .pc_load(pc_load), .pc_load_value(pc_load_value), .table_read_op(table_read_op),
    .table_write_op(1'b0), .table_page_register(table_page_register), .table_offset(table_offset),
    .table_upper(table_upper), .psv_enable(psv_enable), .psv_page(psv_page), .rd_valid(rd_valid),
    .rd_byte(rd_byte), .rd_ea(rd_ea), .wr_valid(wr_valid), .wr_byte(wr_byte), .wr_ea(wr_ea),
    .wr_data(wr_data), .dram_rdata(dram_rdata), .prog_rdata(prog_rdata), .pc(pc),
    .prog_addr(prog_addr), .prog_upper_word(prog_upper_word), .prog_access_ok(prog_access_ok),
    .region_sel(region_sel), .in_primary_vectors(in_primary_vectors),
    .in_alt_vectors(in_alt_vectors), .dram_raddr(dram_raddr), .dram_waddr(dram_waddr),
    .dram_wlane(dram_wlane), .dram_wdata(dram_wdata), .rd_data(rd_data),
    .rd_data_valid(rd_data_valid), .addr_error_trap(addr_error_trap));
  msad_ram_model ram (.clock(clock), .raddr(dram_raddr), .waddr(dram_waddr),
    .wlane(dram_wlane), .wdata(dram_wdata), .rdata(dram_rdata));
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic rd(input logic [15:0] ea, input logic byt, input logic [15:0] exp);
    rd_valid = 1;
    rd_byte = byt;
    rd_ea = ea;
    tick(1);
    rd_valid = 0;
    chk("rd_data", 24'(exp), 24'(rd_data));
    chk("rd_data_valid", 24'h1, 24'(rd_data_valid));
  endtask
  task automatic wr(input logic [15:0] ea, input logic byt, input logic [15:0] d);
    wr_valid = 1;
    wr_byte = byt;
    wr_ea = ea;
    wr_data = d;
    tick(1);
    wr_valid = 0;
  endtask
  task automatic test_pc;
    chk("pc", 24'h0, 24'(pc));
    chk("region_sel", 24'h1, 24'(region_sel));
    pc_advance = 1;
    tick(2);
    chk("pc", 24'h4, 24'(pc));
    chk("in_primary_vectors", 24'h1, 24'(in_primary_vectors));
    pc_reverse = 1;
    tick(1);
    pc_reverse = 0;
    pc_advance = 0;
    chk("pc", 24'h2, 24'(pc));
    pc_load = 1;
    pc_load_value = 23'h000101;
    tick(1);
    pc_load = 0;
    chk("pc", 24'h100, 24'(pc));
    chk("in_alt_vectors", 24'h1, 24'(in_alt_vectors));
    chk("prog_addr", 24'h000100, prog_addr);
    $display("test_pc done");
  endtask
  task automatic test_table;
    table_read_op = 1;
    table_page_register = 8'h80;
    table_upper = 1;
    tick(1);
    chk("prog_upper_word", 24'h1, 24'(prog_upper_word));
    chk("region_sel", 24'h8, 24'(region_sel));
    chk("prog_access_ok", 24'h1, 24'(prog_access_ok));
    table_page_register = 8'h7f;
    tick(1);
    chk("prog_addr", 24'h7f0001, prog_addr);
    chk("prog_access_ok", 24'h1, 24'(prog_access_ok));
    table_read_op = 0;
    $display("test_table done");
  endtask
  task automatic test_data;
    wr(16'h0010, 0, 16'h1234);
    wr(16'h0013, 1, 16'h00ab);
    rd(16'h0011, 1, 16'h0012);
    rd(16'h0010, 1, 16'h0034);
    rd(16'h0012, 0, 16'hab5a);
    $display("test_data done");
  endtask
  task automatic test_errs;
    wr(16'h0015, 0, 16'hffff);
    chk("addr_error_trap", 24'h1, 24'(addr_error_trap));
    rd(16'h0014, 0, 16'h5a5a);
    rd(16'h4000, 0, 16'h0000);
    rd(16'h8000, 0, 16'h0000);
    $display("test_errs done");
  endtask
  task automatic test_regions;
    psv_enable = 1;
    psv_page = 8'h12;
    prog_rdata = 16'hc3a5;
    rd_valid = 1;
    rd_byte = 0;
    rd_ea = 16'h8006;
    #1;
    chk("prog_addr", 24'h120006, prog_addr);
    chk("region_sel", 24'h20, 24'(region_sel));
    tick(1);
    rd_valid = 0;
    chk("rd_data", 24'h00c3a5, 24'(rd_data));
    rd(16'h8007, 1, 16'h00c3);
    psv_enable = 0;
    rd_valid = 1;
    rd_ea = 16'h0010;
    #1;
    chk("region_sel", 24'h10, 24'(region_sel));
    tick(1);
    rd_valid = 0;
    pc_load = 1;
    pc_load_value = 23'h015800;
    tick(1);
    chk("region_sel", 24'h4, 24'(region_sel));
    pc_load_value = 23'h000200;
    tick(1);
    pc_load = 0;
    chk("region_sel", 24'h2, 24'(region_sel));
    $display("test_regions done");
  endtask
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    tick(3);
    rst = 0;
    tick(2);
    test_pc();
    test_table();
    test_data();
    test_errs();
    test_regions();
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- msad_decoder.sv ----
/*
 memory space address decoder: program counter, program address selection,
 region decode, data read/write decode with byte lanes and address error.
 assumes the core issues at most one read and one write per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module msad_decoder
  import msad_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic pc_advance,
  input wire logic pc_reverse,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_load_value,
  input wire logic table_read_op,
  input wire logic table_write_op,
  input wire logic [7:0] table_page_register,
  input wire logic [15:0] table_offset,
  input wire logic table_upper,
  input wire logic psv_enable,
  input wire logic [7:0] psv_page,
  input wire logic rd_valid,
  input wire logic rd_byte,
  input wire logic [EA_W-1:0] rd_ea,
  input wire logic wr_valid,
  input wire logic wr_byte,
  input wire logic [EA_W-1:0] wr_ea,
  input wire logic [WORD_W-1:0] wr_data,
  input wire logic [WORD_W-1:0] dram_rdata,
  input wire logic [WORD_W-1:0] prog_rdata,
  output logic [PC_W-1:0] pc,
  output logic [PADDR_W-1:0] prog_addr,
  output logic prog_upper_word,
  output logic prog_access_ok,
  output logic [REGION_N-1:0] region_sel,
  output logic in_primary_vectors,
  output logic in_alt_vectors,
  output logic [EA_W-2:0] dram_raddr,
  output logic [EA_W-2:0] dram_waddr,
  output logic [1:0] dram_wlane,
  output logic [WORD_W-1:0] dram_wdata,
  output logic [WORD_W-1:0] rd_data,
  output logic rd_data_valid,
  output logic addr_error_trap
);
  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic data_impl(input logic [EA_W-1:0] ea);
    return (ea[EA_W-1] == 1'b0) && (ea <= DATA_IMPL_END_DEF);
  endfunction

  msad_state_t state;
  msad_state_t next_state;
  logic [PC_W-1:0] next_pc;
  logic [PADDR_W-1:0] psv_paddr;
  logic [PADDR_W-1:0] table_paddr;
  logic table_op;
  logic rd_psv;
  logic rd_odd_word;
  logic wr_odd_word;
  logic [WORD_W-1:0] rd_word;
  logic [WORD_W-1:0] rd_sel;
  logic rd_from_prog;
  logic rd_in_dram;
  logic [PADDR_W-1:0] pa;
  logic cfg_half;
  logic user_ok;
  logic cfg_ok;

  msad_psv_map u_psv (
    .psv_page(psv_page),
    .ea(rd_ea),
    .paddr(psv_paddr)
  );

  // counter runs only after reset release; always even
  assign next_state = MSAD_RUN;
  assign next_pc = pc_load ? {pc_load_value[PC_W-1:1], 1'b0} :
                   (state != MSAD_RUN) ? RESET_VECTOR[PC_W-1:0] :
                   pc_reverse ? pc - PC_STEP :
                   pc_advance ? pc + PC_STEP : pc;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= MSAD_IDLE;
      pc <= RESET_VECTOR[PC_W-1:0];
    end else begin
      state <= next_state;
      pc <= next_pc;
    end
  end

  // address source priority: table op, then visibility read, then counter
  assign table_op = table_read_op || table_write_op;
  assign table_paddr = {table_page_register, table_offset[15:1], table_upper};
  assign rd_psv = rd_valid && rd_ea[EA_PSV_BIT] && psv_enable;
  assign pa = table_op ? table_paddr :
              rd_psv ? psv_paddr :
              {1'b0, pc};
  assign prog_addr = pa;
  assign prog_upper_word = pa[0];

  // upper half only for table ops with page bit 7
  assign cfg_half = pa[USER_HALF_BIT];
  assign user_ok = !cfg_half && (pa <= USER_TOP);
  assign cfg_ok = cfg_half && table_op && table_page_register[TBLPAGE_CFG_BIT];
  assign prog_access_ok = user_ok || cfg_ok;

  // vector tables
  assign in_primary_vectors = in_range(pa, IVT_START, IVT_END);
  assign in_alt_vectors = in_range(pa, AIVT_START, AIVT_END);

  // one-hot region select, combinational
  always_comb begin
    region_sel = '0;
    if (rd_valid && !table_op && !rd_ea[EA_PSV_BIT]) begin
      region_sel[REG_DRAM] = 1'b1;
    end else if (rd_psv && !table_op) begin
      region_sel[REG_PSVW] = 1'b1;
    end else if (cfg_half) begin
      region_sel[REG_CONFIG] = 1'b1;
    end else if (pa <= AIVT_END) begin
      region_sel[REG_VECT] = 1'b1;
    end else if (pa <= USER_FLASH_END_DEF) begin
      region_sel[REG_USER] = 1'b1;
    end else begin
      region_sel[REG_UNIMP] = 1'b1;
    end
  end

  // data space: word address, byte lanes
  assign dram_raddr = rd_ea[EA_W-1:1];
  assign dram_waddr = wr_ea[EA_W-1:1];
  assign rd_odd_word = rd_valid && !rd_byte && rd_ea[0];
  assign wr_odd_word = wr_valid && !wr_byte && wr_ea[0];
  // misaligned or out-of-range writes never reach memory
  assign dram_wlane = (!wr_valid || wr_odd_word || !data_impl(wr_ea)) ? 2'b00 :
                      !wr_byte ? 2'b11 :
                      wr_ea[0] ? 2'b10 : 2'b01;
  assign dram_wdata = wr_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;

  // read data: zero outside memory or disabled window
  assign rd_in_dram = data_impl(rd_ea);
  assign rd_from_prog = rd_psv;
  assign rd_word = rd_from_prog ? prog_rdata :
                   rd_in_dram ? dram_rdata : 16'h0000;
  assign rd_sel = !rd_byte ? rd_word :
                  rd_ea[0] ? {8'h00, rd_word[15:8]} : {8'h00, rd_word[7:0]};

  // read completes even when misaligned; trap flagged alongside
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data <= 16'h0000;
      rd_data_valid <= 1'b0;
      addr_error_trap <= 1'b0;
    end else begin
      rd_data <= rd_valid ? rd_sel : rd_data;
      rd_data_valid <= rd_valid;
      addr_error_trap <= rd_odd_word || wr_odd_word;
    end
  end

  // checks
  AST_PC_STEP: assert property (@(posedge clock) disable iff (rst)
    (state == MSAD_RUN && pc_advance && !pc_reverse && !pc_load) |=> pc == $past(pc) + PC_STEP)
    else $error("pc did not advance by two");
  AST_PC_EVEN: assert property (@(posedge clock) disable iff (rst) pc[0] == 1'b0)
    else $error("pc not word aligned");
  AST_RESET_START: assert property (@(posedge clock) $fell(rst) |-> pc == RESET_VECTOR[PC_W-1:0])
    else $error("pc not at reset vector after reset");
  AST_CFG_GATE: assert property (@(posedge clock) disable iff (rst)
    (prog_access_ok && prog_addr[USER_HALF_BIT]) |-> (table_op && table_page_register[TBLPAGE_CFG_BIT]))
    else $error("config region reached without table page bit");
  AST_USER_HALF: assert property (@(posedge clock) disable iff (rst)
    (!table_op && prog_access_ok) |-> prog_addr <= USER_TOP)
    else $error("user access above lower half");
  AST_ONEHOT: assert property (@(posedge clock) disable iff (rst) $onehot(region_sel))
    else $error("region select not one-hot");
  AST_ZERO_OUT: assert property (@(posedge clock) disable iff (rst)
    (rd_valid && !rd_ea[EA_PSV_BIT] && rd_ea > DATA_IMPL_END_DEF) |=> rd_data == 16'h0000)
    else $error("out of range read not zero");
  AST_BYTE_HI: assert property (@(posedge clock) disable iff (rst)
    (rd_valid && rd_byte) |=> rd_data[15:8] == 8'h00)
    else $error("byte read high byte not zero");
  AST_TRAP_WR: assert property (@(posedge clock) disable iff (rst)
    (wr_valid && !wr_byte && wr_ea[0]) |-> (dram_wlane == 2'b00) ##1 addr_error_trap)
    else $error("misaligned write not suppressed or trapped");
  AST_PSV_GATE: assert property (@(posedge clock) disable iff (rst)
    (rd_valid && rd_ea[EA_PSV_BIT] && !psv_enable) |=> rd_data == 16'h0000)
    else $error("window read without visibility enable");
  AST_VECT: assert property (@(posedge clock) disable iff (rst)
    (!table_op && !rd_valid && in_primary_vectors) |-> region_sel[REG_VECT])
    else $error("vector table not decoded");

  COV_BYTE_ODD: cover property (@(posedge clock) disable iff (rst) rd_valid && rd_byte && rd_ea[0]);
  COV_PSV_READ: cover property (@(posedge clock) disable iff (rst) rd_psv);
  COV_CFG_TABLE: cover property (@(posedge clock) disable iff (rst) cfg_ok);
  COV_TRAP: cover property (@(posedge clock) disable iff (rst) addr_error_trap);
endmodule
`default_nettype wire

// ---- msad_pkg.sv ----
/*
 package for the memory space address decoder: program and data space
 boundaries, region encodings and bit positions. assumes nothing.
*/
package msad_pkg;
  localparam int PADDR_W = 24;
  localparam int PC_W = 23;
  localparam int EA_W = 16;
  localparam int WORD_W = 16;
  localparam logic [23:0] RESET_VECTOR = 24'h000000;
  localparam logic [23:0] RESET_TARGET_ADDR = 24'h000002;
  localparam logic [23:0] IVT_START = 24'h000004;
  localparam logic [23:0] IVT_END = 24'h0000ff;
  localparam logic [23:0] AIVT_START = 24'h000100;
  localparam logic [23:0] AIVT_END = 24'h0001ff;
  localparam logic [23:0] USER_FLASH_END_DEF = 24'h0157fe;
  localparam logic [23:0] USER_TOP = 24'h7fffff;
  localparam int TBLPAGE_CFG_BIT = 7;
  localparam int USER_HALF_BIT = 23;
  localparam int EA_PSV_BIT = 15;
  localparam logic [15:0] DATA_IMPL_END_DEF = 16'h3fff;
  localparam logic [22:0] PC_STEP = 23'h000002;
  localparam logic [7:0] TBLPAGE_RESET = 8'h00;
  localparam int REGION_N = 6;
  localparam int REG_VECT = 0;
  localparam int REG_USER = 1;
  localparam int REG_UNIMP = 2;
  localparam int REG_CONFIG = 3;
  localparam int REG_DRAM = 4;
  localparam int REG_PSVW = 5;
  typedef enum logic [1:0] {MSAD_SRC_PC, MSAD_SRC_TABLE, MSAD_SRC_PSV} msad_src_t;
  typedef enum {MSAD_IDLE, MSAD_RUN} msad_state_t;
endpackage

// ---- msad_psv_map.sv ----
/*
 program space visibility mapping: page plus low ea bits into a 24-bit program
 address. assumes the caller qualifies the access with the visibility enable.
*/
`timescale 1ns/1ps
`default_nettype none
module msad_psv_map
  import msad_pkg::*;
(
  input wire logic [7:0] psv_page,
  input wire logic [EA_W-1:0] ea,
  output logic [PADDR_W-1:0] paddr
);
  // window is 32 kbyte; page supplies the upper bits
  assign paddr = {psv_page[7:0], 1'b0, ea[14:0]};
endmodule
`default_nettype wire

// ---- msad_ram_model.sv ----
/*
 behavioural data ram standing behind the decoder's data ports.
 assumes word addresses and byte lanes come from the decoder.
*/
`timescale 1ns/1ps
`default_nettype none
module msad_ram_model (
  input wire logic clock,
  input wire logic [14:0] raddr,
  input wire logic [14:0] waddr,
  input wire logic [1:0] wlane,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:32767];
  // nonzero fill, so a forced zero read is visible
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 16'h5a5a;
  end
  assign rdata = mem[raddr];
  always @(posedge clock) begin
    if (wlane[0]) mem[waddr][7:0] <= wdata[7:0];
    if (wlane[1]) mem[waddr][15:8] <= wdata[15:8];
  end
endmodule
`default_nettype wire
